// file: rtl/l1c_top.sv
// l1c_top.sv: level-one instruction and data caches with fill buffer and register slave
`include "l1c_defines.svh"
module l1c_top
   import l1c_pkg::*;
#(
   parameter int IC_SET_W = `L1C_IC_SET_W,
   parameter int DC_SET_W = `L1C_DC_SET_W
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        if_req,
   input  wire logic [31:0] if_va,
   input  wire logic [31:0] if_pa,
   output logic             if_ack,
   output logic      [31:0] if_rdata,
   input  wire logic        ls_req,
   input  wire logic        ls_we,
   input  wire logic [31:0] ls_va,
   input  wire logic [31:0] ls_pa,
   input  wire logic [31:0] ls_wdata,
   output logic             ls_ack,
   output logic      [31:0] ls_rdata,
   input  wire logic        cop_req,
   input  wire logic        cop_dside,
   input  wire logic        cop_lock,
   input  wire logic [31:0] cop_va,
   input  wire logic [31:0] cop_pa,
   output logic             cop_ack,
   output logic             bus_req,
   output logic             bus_we,
   output logic      [31:0] bus_addr,
   output logic      [31:0] bus_wdata,
   input  wire logic        bus_ack,
   input  wire logic [31:0] bus_rdata
);
   localparam int WW       = `L1C_WORD_W;
   localparam int IC_LINES = (1 << IC_SET_W) * `L1C_WAYS;
   localparam int DC_LINES = (1 << DC_SET_W) * `L1C_WAYS;

   l1c_st_t  r;
   l1c_st_t  n;

   // arrays: tags, ages and dirty bits are separate from the data words
   l1c_tag_t  ic_tag  [IC_LINES];
   l1c_age_t  ic_age  [1 << IC_SET_W];
   logic [31:0] ic_data [IC_LINES << WW];
   l1c_tag_t  dc_tag  [DC_LINES];
   l1c_meta_t dc_meta [1 << DC_SET_W];
   logic [31:0] dc_data [DC_LINES << WW];

   l1c_repl_if ic_rp ();
   l1c_repl_if dc_rp ();

   l1c_victim u_ic_victim (.rp(ic_rp));
   l1c_victim u_dc_victim (.rp(dc_rp));
   l1c_age    u_ic_age    (.rp(ic_rp));
   l1c_age    u_dc_age    (.rp(dc_rp));

   logic [31:0]           k_va;
   logic [31:0]           k_pa;
   l1c_kind_t             k_kind;
   logic                  k_side;
   logic                  op_any;
   logic [IC_SET_W-1:0]   ic_set;
   logic [DC_SET_W-1:0]   dc_set;
   logic [WW-1:0]         wsel;
   logic [`L1C_TAG_W-1:0] ptag;
   logic [`L1C_WAYS-1:0]  ic_hv;
   logic [`L1C_WAYS-1:0]  dc_hv;
   logic [`L1C_WAY_W-1:0] hway;
   logic                  en;
   logic                  hit;
   logic                  found;
   logic [`L1C_WAY_W-1:0] victim;
   logic                  vdirty;
   logic [`L1C_TAG_W-1:0] vtag;
   logic                  miss;
   logic                  tag_wr;
   logic                  lck_wr;
   logic                  age_wr;
   logic                  dirty_set;
   logic                  inval;
   logic                  dat_wr;
   logic [`L1C_WAY_W-1:0] dat_way;
   logic [WW-1:0]         dat_word;
   logic [31:0]           dat_val;

   ////////////////////////////////////////////////////////////////////////////
   // operation select: maintenance, then load/store, then fetch
   always_comb begin
      op_any = 1'b1;
      k_va   = if_va;
      k_pa   = if_pa;
      k_kind = L1C_K_IF;
      k_side = 1'b0;
      if (r.st != L1C_IDLE) begin
         k_va   = r.va;
         k_pa   = r.pa;
         k_kind = r.kind;
         k_side = r.side;
      end else if (cop_req && !r.cop_ack) begin
         k_va   = cop_va;
         k_pa   = cop_pa;
         k_kind = L1C_K_COP;
         k_side = cop_dside;
      end else if (ls_req && !r.ls_ack) begin
         k_va   = ls_va;
         k_pa   = ls_pa;
         k_kind = ls_we ? L1C_K_ST : L1C_K_LD;
         k_side = 1'b1;
      end else begin
         op_any = if_req && !r.if_ack;
      end
   end

   // set picked by virtual bits while the physical tag is compared alongside
   assign ic_set = k_va[IC_SET_W+3:4];
   assign dc_set = k_va[DC_SET_W+3:4];
   assign wsel   = k_va[3:2];
   assign ptag   = k_pa[31:`L1C_TAG_LSB];

   always_comb begin
      hway = '0;
      for (int w = 0; w < `L1C_WAYS; w++) begin
         ic_hv[w]       = ic_tag[{ic_set, `L1C_WAY_W'(w)}].valid &&
                          ic_tag[{ic_set, `L1C_WAY_W'(w)}].tag == ptag;
         dc_hv[w]       = dc_tag[{dc_set, `L1C_WAY_W'(w)}].valid &&
                          dc_tag[{dc_set, `L1C_WAY_W'(w)}].tag == ptag;
         ic_rp.valid[w] = ic_tag[{ic_set, `L1C_WAY_W'(w)}].valid;
         ic_rp.lock[w]  = ic_tag[{ic_set, `L1C_WAY_W'(w)}].lock;
         dc_rp.valid[w] = dc_tag[{dc_set, `L1C_WAY_W'(w)}].valid;
         dc_rp.lock[w]  = dc_tag[{dc_set, `L1C_WAY_W'(w)}].lock;
         if (k_side ? dc_hv[w] : ic_hv[w]) begin
            hway = `L1C_WAY_W'(w);
         end
      end
   end

   assign ic_rp.age   = ic_age[ic_set];
   assign dc_rp.age   = dc_meta[dc_set].age;
   assign ic_rp.touch = (r.st == L1C_IDLE) ? hway : r.way;
   assign dc_rp.touch = (r.st == L1C_IDLE) ? hway : r.way;
   assign en     = k_side ? r.ctrl[`L1C_CTRL_DEN] : r.ctrl[`L1C_CTRL_IEN];
   assign hit    = en && (k_side ? |dc_hv : |ic_hv);
   assign found  = k_side ? dc_rp.found : ic_rp.found;
   assign victim = k_side ? dc_rp.victim : ic_rp.victim;
   assign vtag   = dc_tag[{dc_set, dc_rp.victim}].tag;
   assign vdirty = dc_meta[dc_set].dirty[dc_rp.victim] &&
                   dc_tag[{dc_set, dc_rp.victim}].valid;

   ////////////////////////////////////////////////////////////////////////////
   // control: register slave and cache sequencer
   always_comb begin
      n         = r;
      n.if_ack  = 1'b0;
      n.ls_ack  = 1'b0;
      n.cop_ack = 1'b0;
      n.av_wait = 1'b1;
      miss      = 1'b0;
      tag_wr    = 1'b0;
      lck_wr    = 1'b0;
      age_wr    = 1'b0;
      dirty_set = 1'b0;
      inval     = 1'b0;
      dat_wr    = 1'b0;
      dat_way   = hway;
      dat_word  = wsel;
      dat_val   = ls_wdata;
      // register slave: one wait cycle, then the access completes
      if ((avs_read || avs_write) && r.av_wait) begin
         n.av_wait = 1'b0;
         case (avs_address)
            `L1C_REG_CTRL:   n.av_rdata = {30'h0, r.ctrl};
            `L1C_REG_STATUS: n.av_rdata = {27'h0, r.lfb_vld, r.st};
            `L1C_REG_HITS:   n.av_rdata = 32'(r.hits);
            `L1C_REG_MISSES: n.av_rdata = 32'(r.misses);
            default:         n.av_rdata = 32'h0;
         endcase
      end
      if (avs_write && !r.av_wait && avs_address == `L1C_REG_CTRL) begin
         n.ctrl = avs_writedata[1:0];
         inval  = avs_writedata[`L1C_CTRL_INV];
         if (inval) begin
            n.lfb_vld = 1'b0;
         end
      end
      case (r.st)
         L1C_IDLE: begin
            if (op_any) begin
               n.va    = k_va;
               n.pa    = k_pa;
               n.kind  = k_kind;
               n.side  = k_side;
               n.way   = victim;
               n.alloc = en && found;
               case (k_kind)
                  L1C_K_COP: begin
                     if (hit) begin
                        lck_wr    = 1'b1;
                        n.cop_ack = 1'b1;
                     end else if (cop_lock && en && found) begin
                        miss = 1'b1;
                     end else begin
                        n.cop_ack = 1'b1;
                     end
                  end
                  L1C_K_IF: begin
                     if (hit) begin
                        n.if_rdata = ic_data[{ic_set, hway, wsel}];
                        n.if_ack   = 1'b1;
                        age_wr     = 1'b1;
                        n.hits     = r.hits + 1'b1;
                     end else if (en && r.lfb_vld && r.lfb_line == k_pa[31:4]) begin
                        n.if_rdata = r.lfb[wsel];
                        n.if_ack   = 1'b1;
                        n.hits     = r.hits + 1'b1;
                     end else begin
                        miss = 1'b1;
                     end
                  end
                  default: begin
                     if (hit) begin
                        n.ls_rdata = dc_data[{dc_set, hway, wsel}];
                        n.ls_ack   = 1'b1;
                        age_wr     = 1'b1;
                        n.hits     = r.hits + 1'b1;
                        if (k_kind == L1C_K_ST) begin
                           dat_wr    = 1'b1;
                           dat_val   = ls_wdata;
                           dirty_set = 1'b1;
                        end
                     end else begin
                        miss = 1'b1;
                     end
                  end
               endcase
            end
            if (miss) begin
               n.misses  = r.misses + 1'b1;
               n.cnt     = '0;
               n.bus_req = 1'b1;
               if (k_kind == L1C_K_ST && !(en && found)) begin
                  n.st        = L1C_UNC;
                  n.bus_we    = 1'b1;
                  n.bus_addr  = k_pa;
                  n.bus_wdata = ls_wdata;
               end else if (en && found && k_side && vdirty) begin
                  n.st        = L1C_WB;
                  n.bus_we    = 1'b1;
                  n.bus_addr  = {vtag, k_pa[`L1C_TAG_LSB-1:4], 4'h0};
                  n.bus_wdata = dc_data[{dc_set, dc_rp.victim, 2'h0}];
               end else begin
                  n.st       = L1C_FILL;
                  n.bus_we   = 1'b0;
                  n.bus_addr = {k_pa[31:4], 4'h0};
               end
            end
         end
         L1C_WB: begin
            if (bus_ack) begin
               n.cnt      = r.cnt + 1'b1;
               n.bus_addr = r.bus_addr + 32'h4;
               n.bus_wdata = dc_data[{dc_set, r.way, WW'(r.cnt + 1'b1)}];
               if (r.cnt == '1) begin
                  n.st       = L1C_FILL;
                  n.bus_we   = 1'b0;
                  n.bus_addr = {r.pa[31:4], 4'h0};
               end
            end
         end
         L1C_FILL: begin
            if (bus_ack) begin
               n.lfb[r.cnt] = bus_rdata;
               dat_wr       = r.alloc;
               dat_way      = r.way;
               dat_word     = r.cnt;
               dat_val      = bus_rdata;
               // critical word goes to the requester as it arrives
               if (r.cnt == r.va[3:2] && r.kind == L1C_K_IF) begin
                  n.if_rdata = bus_rdata;
                  n.if_ack   = 1'b1;
               end
               if (r.cnt == r.va[3:2] && r.kind == L1C_K_LD) begin
                  n.ls_rdata = bus_rdata;
                  n.ls_ack   = 1'b1;
               end
               n.cnt      = r.cnt + 1'b1;
               n.bus_addr = r.bus_addr + 32'h4;
               if (r.cnt == '1) begin
                  n.st       = L1C_IDLE;
                  n.bus_req  = 1'b0;
                  tag_wr     = r.alloc;
                  age_wr     = r.alloc;
                  n.lfb_vld  = !r.side;
                  n.lfb_line = r.pa[31:4];
               end
            end
         end
         L1C_UNC: begin
            // store with no way to allocate goes straight to the bus
            if (bus_ack) begin
               n.st      = L1C_IDLE;
               n.bus_req = 1'b0;
               n.bus_we  = 1'b0;
               n.ls_ack  = 1'b1;
            end
         end
         default: n.st = L1C_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r         <= '0;
         r.st      <= L1C_IDLE;
         r.kind    <= L1C_K_IF;
         r.av_wait <= 1'b1;
         r.ctrl    <= `L1C_CTRL_RST;
      end else if (clk_en) begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tag, lock, age and dirty arrays; invalidate clears every line at once
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < IC_LINES; i++) begin
            ic_tag[i] <= '0;
         end
         for (int i = 0; i < DC_LINES; i++) begin
            dc_tag[i] <= '0;
         end
         for (int s = 0; s < (1 << IC_SET_W); s++) begin
            for (int w = 0; w < `L1C_WAYS; w++) begin
               ic_age[s][w] <= `L1C_WAY_W'(w);
            end
         end
         for (int s = 0; s < (1 << DC_SET_W); s++) begin
            dc_meta[s].dirty <= '0;
            for (int w = 0; w < `L1C_WAYS; w++) begin
               dc_meta[s].age[w] <= `L1C_WAY_W'(w);
            end
         end
      end else if (clk_en) begin
         if (inval) begin
            for (int i = 0; i < IC_LINES; i++) begin
               ic_tag[i].valid <= 1'b0;
               ic_tag[i].lock  <= 1'b0;
            end
            for (int i = 0; i < DC_LINES; i++) begin
               dc_tag[i].valid <= 1'b0;
               dc_tag[i].lock  <= 1'b0;
            end
         end else begin
            if (tag_wr && k_side) begin
               dc_tag[{dc_set, r.way}]      <= '{valid: 1'b1, lock: 1'b0, tag: ptag};
               dc_meta[dc_set].dirty[r.way] <= 1'b0;
            end
            if (tag_wr && !k_side) begin
               ic_tag[{ic_set, r.way}] <= '{valid: 1'b1, lock: 1'b0, tag: ptag};
            end
            if (lck_wr && k_side) begin
               dc_tag[{dc_set, hway}].lock <= cop_lock;
            end
            if (lck_wr && !k_side) begin
               ic_tag[{ic_set, hway}].lock <= cop_lock;
            end
            if (dirty_set) begin
               dc_meta[dc_set].dirty[hway] <= 1'b1;
            end
            if (age_wr && k_side) begin
               dc_meta[dc_set].age <= dc_rp.age_new;
            end
            if (age_wr && !k_side) begin
               ic_age[ic_set] <= ic_rp.age_new;
            end
         end
      end
   end

   // data words carry no reset; valid bits guard them
   always_ff @(posedge sys_clk) begin
      if (clk_en && dat_wr && k_side) begin
         dc_data[{dc_set, dat_way, dat_word}] <= dat_val;
      end
      if (clk_en && dat_wr && !k_side) begin
         ic_data[{ic_set, dat_way, dat_word}] <= dat_val;
      end
   end

   assign avs_readdata    = r.av_rdata;
   assign avs_waitrequest = r.av_wait;
   assign if_ack          = r.if_ack;
   assign if_rdata        = r.if_rdata;
   assign ls_ack          = r.ls_ack;
   assign ls_rdata        = r.ls_rdata;
   assign cop_ack         = r.cop_ack;
   assign bus_req         = r.bus_req;
   assign bus_we          = r.bus_we;
   assign bus_addr        = r.bus_addr;
   assign bus_wdata       = r.bus_wdata;
endmodule

// file: rtl/l1c_defines.svh
// l1c_defines.svh: constants of the level-one instruction and data cache block
`ifndef L1C_DEFINES_SVH
`define L1C_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - instruction cache holds 16 Kbytes of instruction lines
// - instruction cache indexed by virtual address, translation runs alongside lookup
// - every tag entry holds 22 physical address bits, valid bit, lock bit
// - instruction cache replacement ages live in their own array
// - a line fill buffer collects refill words as they are written to the array
// - fetches are served from the fill buffer or straight from the bus
// - each instruction line is locked or unlocked by the maintenance operation
// - data cache holds 4 Kbytes, virtually indexed, physically tagged
// - data cache keeps dirty bits and replacement ages per set together
// - a store hitting a locked data line still updates the line
// - a data miss never evicts a locked line
// - each data line is locked or unlocked by the maintenance operation
////////////////////////////////////////////////////////////////////////////////
`define L1C_TAG_W      22
`define L1C_TAG_LSB    10
`define L1C_WAYS       4
`define L1C_WAY_W      2
`define L1C_WORD_W     2
`define L1C_IC_SET_W   8
`define L1C_DC_SET_W   6
`define L1C_CNT_W      16
`define L1C_REG_CTRL   4'h0
`define L1C_REG_STATUS 4'h4
`define L1C_REG_HITS   4'h8
`define L1C_REG_MISSES 4'hc
`define L1C_CTRL_IEN   0
`define L1C_CTRL_DEN   1
`define L1C_CTRL_INV   2
`define L1C_CTRL_RST   2'h3
`endif

// file: rtl/l1c_pkg.sv
// l1c_pkg.sv: types of the level-one cache block
`include "l1c_defines.svh"
package l1c_pkg;
   typedef enum logic [3:0] {
      L1C_IDLE = 4'b0001,
      L1C_WB   = 4'b0010,
      L1C_FILL = 4'b0100,
      L1C_UNC  = 4'b1000
   } l1c_state_t;

   typedef enum logic [1:0] {
      L1C_K_IF  = 2'h0,
      L1C_K_LD  = 2'h1,
      L1C_K_ST  = 2'h2,
      L1C_K_COP = 2'h3
   } l1c_kind_t;

   typedef logic [`L1C_WAYS-1:0][`L1C_WAY_W-1:0] l1c_age_t;

   typedef struct packed {
      logic                  valid;
      logic                  lock;
      logic [`L1C_TAG_W-1:0] tag;
   } l1c_tag_t;

   typedef struct packed {
      logic [`L1C_WAYS-1:0] dirty;
      l1c_age_t             age;
   } l1c_meta_t;

   typedef struct packed {
      l1c_state_t                 st;
      l1c_kind_t                  kind;
      logic                       side;
      logic                       alloc;
      logic [`L1C_WAY_W-1:0]      way;
      logic [`L1C_WORD_W-1:0]     cnt;
      logic [31:0]                va;
      logic [31:0]                pa;
      logic [3:0][31:0]           lfb;
      logic                       lfb_vld;
      logic [27:0]                lfb_line;
      logic                       if_ack;
      logic [31:0]                if_rdata;
      logic                       ls_ack;
      logic [31:0]                ls_rdata;
      logic                       cop_ack;
      logic                       bus_req;
      logic                       bus_we;
      logic [31:0]                bus_addr;
      logic [31:0]                bus_wdata;
      logic                       av_wait;
      logic [31:0]                av_rdata;
      logic [1:0]                 ctrl;
      logic [`L1C_CNT_W-1:0]      hits;
      logic [`L1C_CNT_W-1:0]      misses;
   } l1c_st_t;
endpackage

// file: rtl/l1c_repl_if.sv
// l1c_repl_if.sv: replacement state of one set, passed to victim and aging logic
`include "l1c_defines.svh"
interface l1c_repl_if;
   import l1c_pkg::*;
   l1c_age_t              age;
   logic [`L1C_WAYS-1:0]  valid;
   logic [`L1C_WAYS-1:0]  lock;
   logic [`L1C_WAY_W-1:0] touch;
   l1c_age_t              age_new;
   logic [`L1C_WAY_W-1:0] victim;
   logic                  found;

   modport pick (input age, input valid, input lock, output victim, output found);
   modport aging (input age, input touch, output age_new);
endinterface

// file: rtl/l1c_victim.sv
// l1c_victim.sv: picks the way to replace among the unlocked ways of a set
`include "l1c_defines.svh"
module l1c_victim
   import l1c_pkg::*;
(
   l1c_repl_if.pick rp
);
   logic                  inv;
   logic [`L1C_WAY_W-1:0] best;

   // an empty unlocked way first, else the oldest unlocked one
   always_comb begin
      inv       = 1'b0;
      best      = '0;
      rp.victim = '0;
      rp.found  = 1'b0;
      for (int w = 0; w < `L1C_WAYS; w++) begin
         if (!rp.lock[w]) begin
            if (!rp.valid[w] && !inv) begin
               inv       = 1'b1;
               rp.victim = `L1C_WAY_W'(w);
               rp.found  = 1'b1;
            end else if (!inv && (!rp.found || rp.age[w] > best)) begin
               best      = rp.age[w];
               rp.victim = `L1C_WAY_W'(w);
               rp.found  = 1'b1;
            end
         end
      end
   end
endmodule

// file: rtl/l1c_age.sv
// l1c_age.sv: next replacement ages of a set after one way is touched
`include "l1c_defines.svh"
module l1c_age
   import l1c_pkg::*;
(
   l1c_repl_if.aging rp
);
   // ages stay a permutation: touched way goes to zero, younger ones age
   always_comb begin
      for (int w = 0; w < `L1C_WAYS; w++) begin
         if (`L1C_WAY_W'(w) == rp.touch) begin
            rp.age_new[w] = '0;
         end else if (rp.age[w] < rp.age[rp.touch]) begin
            rp.age_new[w] = rp.age[w] + 1'b1;
         end else begin
            rp.age_new[w] = rp.age[w];
         end
      end
   end
endmodule

// file: tb/l1c_top_assertions.sv
// l1c_top_assertions.sv: port checker for the cache block
module l1c_chk (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        if_req,
   input wire logic        if_ack,
   input wire logic        ls_req,
   input wire logic        ls_ack,
   input wire logic        cop_ack,
   input wire logic        bus_req,
   input wire logic        bus_we,
   input wire logic        bus_ack,
   input wire logic [31:0] bus_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence fill_mid;
      bus_ack && !bus_we && bus_addr[3:2] != 2'h3;
   endsequence
   ////////////////////////////////
   // register slave: one wait cycle, then one answer cycle
   AST_AV_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("register answer late");
   AST_AV_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("register answer too long");
   // answers are single pulses; fetch and load/store ones caused by a request
   AST_IF_ONE: assert property (not (if_ack ##1 if_ack))
      else $error("fetch ack too long");
   AST_IF_CAUSE: assert property (if_ack |-> $past(if_req))
      else $error("fetch ack unasked");
   AST_LS_ONE: assert property (ls_ack |-> $past(ls_req) ##1 !ls_ack)
      else $error("load store ack wrong");
   AST_COP_ONE: assert property (cop_ack |=> !cop_ack)
      else $error("maintenance ack too long");
   // fills: request held, line start first, words ascend by four bytes
   AST_BUS_HOLD: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
      else $error("bus request dropped");
   AST_LINE_START: assert property ($rose(bus_req) && !bus_we |-> bus_addr[3:0] == 4'h0)
      else $error("fill not at line start");
   AST_FILL_STEP: assert property (fill_mid |=>
      bus_req && bus_addr == $past(bus_addr) + 32'h4)
      else $error("fill word order");
   cover property (if_ack);
   cover property (bus_ack && bus_we);
   cover property (cop_ack);
endmodule
bind l1c_top l1c_chk u_chk (.*);

// file: tb/l1c_mem.sv
// l1c_mem.sv: behavioural memory on the cache's line fill bus
module l1c_mem (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        slow,
   input  wire logic        bus_req,
   input  wire logic        bus_we,
   input  wire logic [31:0] bus_addr,
   input  wire logic [31:0] bus_wdata,
   output logic             bus_ack,
   output logic      [31:0] bus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [logic [31:0]];
   logic [1:0]  wait_q;
   // one ack per word; slow mode stalls, idle data toggles so stale reads show
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bus_ack <= 1'b0;
         wait_q <= 2'h0;
         bus_rdata <= 32'h0;
      end else if (bus_req && !bus_ack && (!slow || wait_q == 2'h3)) begin
         bus_ack <= 1'b1;
         wait_q <= 2'h0;
         if (bus_we) mem[bus_addr] = bus_wdata;
         bus_rdata <= mem.exists(bus_addr) ? mem[bus_addr] : bus_addr ^ 32'ha5a5a5a5;
      end else begin
         bus_ack <= 1'b0;
         wait_q <= (bus_req && !bus_ack) ? wait_q + 2'h1 : 2'h0;
         bus_rdata <= ~bus_rdata;
      end
   end
endmodule

// file: tb/test_l1c_top.sv
// test_l1c_top.sv: seeded cache traffic checked through an expectation queue
module test_l1c_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, nrst = 1'b0, slow = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic        if_req = 1'b0, ls_req = 1'b0, ls_we = 1'b0, cop_req = 1'b0;
   logic        cop_dside = 1'b0, cop_lock = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, if_va = 32'h0, if_pa = 32'h0, ls_va = 32'h0;
   logic [31:0] ls_pa = 32'h0, ls_wdata = 32'h0, cop_va = 32'h0, cop_pa = 32'h0;
   logic        avs_waitrequest, if_ack, ls_ack, cop_ack, bus_req, bus_we, bus_ack;
   logic [31:0] avs_readdata, if_rdata, ls_rdata, bus_addr, bus_wdata, bus_rdata;
   logic [31:0] exp_q [$];
   int          miscompares = 0, checks_done = 0, fills = 0, seed = 28197;
   l1c_top #(.IC_SET_W(6), .DC_SET_W(6)) dut (.clk_en(1'b1), .*);
   l1c_mem mem_i (.*);
   always #20 sys_clk = ~sys_clk;
   ////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // untouched memory answers with the address scrambled
   function automatic logic [31:0] m(input logic [31:0] a);
      return a ^ 32'ha5a5a5a5;
   endfunction
   // register access; for a read d is the expected value
   task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      if (!w) exp_q.push_back(d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) miscompares++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // k: 0 fetch, 1 load, 2 store, 4/5 lock instr/data line
   task automatic op(input logic [2:0] k, input logic [31:0] a, d, e);
      int n = 0;
      @(posedge sys_clk);
      if (k < 3'h2) exp_q.push_back(e);
      {if_va, if_pa, ls_va, ls_pa, cop_va, cop_pa} <= {6{a}};
      ls_wdata <= d;
      ls_we <= k == 3'h2;
      if_req <= k == 3'h0;
      ls_req <= k == 3'h1 || k == 3'h2;
      {cop_req, cop_dside, cop_lock} <= {k[2], k[0], 1'b1};
      do begin
         @(posedge sys_clk);
         n++;
      end while ((if_ack | ls_ack | cop_ack) !== 1'b1 && n < 2000);
      if (n >= 2000) miscompares++;
      {if_req, ls_req, cop_req} <= 3'h0;
   endtask
   // results leave the queue in order as each answer pulse appears
   always @(posedge sys_clk) begin
      if (if_ack === 1'b1 || (ls_ack === 1'b1 && ls_we === 1'b0) ||
          (avs_read === 1'b1 && avs_waitrequest === 1'b0))
         chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hx,
             if_ack ? if_rdata : ls_ack ? ls_rdata : avs_readdata);
      if (bus_ack && !bus_we && bus_addr[3:2] == 2'h3) fills++;
   end
   initial begin
      logic [31:0] b, v;
      int f;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      rg(0, 4'h0, 32'h3);
      rg(0, 4'h4, 32'h1);
      rg(0, 4'h2, 32'h0);
      rg(1, 4'h0, 32'h0);
      rg(0, 4'h0, 32'h0);
      rg(1, 4'h0, 32'h3);
      // s=0 instruction side, prompt bus; s=1 data side, slow bus
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         b = $random(seed) & 32'h0fff_fff0;
         v = $random(seed);
         op(3'(s), b, 0, m(b));
         op(3'(s), b + 32'h4, 0, m(b + 32'h4));
         op(3'(4 + s), b, 0, 0);
         if (s == 1) op(3'h2, b, v, 0);
         if (s == 1) op(3'h2, b + 32'h400, v, 0);
         f = fills; // no fill in flight here, unlike after a critical-word ack
         for (int j = 2; j < 6; j++)
            op(3'(s), b + 32'(j) * 32'h400, 0, m(b + 32'(j) * 32'h400));
         op(3'(s), b, 0, s == 1 ? v : m(b));
         chk("fills", 32'(f + 4), 32'(fills));
         if (s == 1) op(3'h1, b + 32'h400, 0, v);
      end
      rg(0, 4'hc, 32'hc); // twelve misses and six hits over both passes
      rg(0, 4'h8, 32'h6);
      @(posedge sys_clk);
      chk("queue", 32'h0, 32'(exp_q.size()));
      tally_and_finish;
   end
   // the whole run needs a few hundred cycles; 50000 means a hang
   initial begin
      #2000000;
      miscompares++;
      tally_and_finish;
   end
endmodule
